// ===== design/dacc_chan.sv
// one dac channel: conversion timer, result latch and output code register
// assumes control and data come from logic on core_clk
`timescale 1ns/1ps
`include "dacc_regs.svh"

module dacc_chan (
  input wire logic core_clk,
  input wire logic srst,
  input wire dacc_pkg::dacc_chan_ctl_type ctl,
  input wire logic [7:0] data,
  input wire logic restart,
  input wire logic flush,
  output dacc_pkg::dacc_chan_out_type out
);

  localparam logic [`DACC_CNT_W-1:0] LAST = `DACC_CNT_W'(`DACC_CONV_CYCLES - 1);

  dacc_pkg::dacc_state_type state_reg, state_next;
  logic [`DACC_CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] code_reg, code_next;
  logic [7:0] pin_reg, pin_next;
  logic have_reg, have_next;

  wire cnt_done = (state_reg == dacc_pkg::ST_CONVERT) && (cnt_reg == LAST);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    code_next = code_reg;
    have_next = have_reg;
    if (ctl.hold) begin
      // standby: everything frozen so the output is retained [RQ15]
      state_next = state_reg;
    end else if (!ctl.conv_active) begin
      state_next = dacc_pkg::ST_IDLE;
      cnt_next = '0;
      have_next = 1'b0;
    end else if (restart || flush || state_reg == dacc_pkg::ST_IDLE) begin
      // data write restarts at once; old result stays until the new one [RQ11] [RQ10]
      state_next = dacc_pkg::ST_CONVERT;
      cnt_next = '0;
      if (flush) begin
        have_next = 1'b0;
      end
    end else if (cnt_done) begin
      state_next = dacc_pkg::ST_READY;
      code_next = data;
      have_next = 1'b1;
    end else if (state_reg == dacc_pkg::ST_CONVERT) begin
      cnt_next = cnt_reg + `DACC_CNT_W'(1);
    end
    // code drives the analog stage: level = code / 256 * vref [RQ12] [RQ9]
    pin_next = (ctl.out_enable && have_next) ? code_next : `DACC_CODE_OFF;
    if (ctl.hold) begin
      pin_next = pin_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= dacc_pkg::ST_IDLE;
      cnt_reg <= '0;
      code_reg <= `DACC_DATA_RESET;
      pin_reg <= `DACC_CODE_OFF;
      have_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      code_reg <= code_next;
      pin_reg <= pin_next;
      have_reg <= have_next;
    end
  end

  assign out.code = pin_reg;
  assign out.out_enable = ctl.out_enable;
  assign out.converting = ctl.conv_active;

  a_result_wait: assert property (@(posedge core_clk) disable iff (srst) // [RQ9]
    $rose(have_reg) |-> $past(cnt_reg) == LAST && $past(state_reg) == dacc_pkg::ST_CONVERT)
    else $error("result appeared before conversion time");

  a_flush_hides: assert property (@(posedge core_clk) disable iff (srst) // [RQ9]
    (flush && ctl.conv_active && !ctl.hold) |=> !have_reg ##1 !have_reg)
    else $error("old result shown after output enable set");

  a_code_match: assert property (@(posedge core_clk) disable iff (srst) // [RQ12]
    ($past(ctl.out_enable) && !$past(ctl.hold) && have_reg) |-> pin_reg == code_reg)
    else $error("output code differs from converted data");

  a_off_zero: assert property (@(posedge core_clk) disable iff (srst) // [RQ13]
    (!ctl.out_enable && !ctl.hold) |=> pin_reg == `DACC_CODE_OFF)
    else $error("output not disabled");

  a_standby_hold: assert property (@(posedge core_clk) disable iff (srst) // [RQ15]
    ctl.hold |=> $stable(pin_reg) && $stable(have_reg))
    else $error("output changed in standby");

  a_restart_keeps: assert property (@(posedge core_clk) disable iff (srst) // [RQ10]
    (restart && !flush && ctl.conv_active && !ctl.hold && have_reg && $past(ctl.out_enable)
     && ctl.out_enable) |=> $stable(pin_reg))
    else $error("output dropped on data rewrite");

endmodule : dacc_chan

// ===== design/dacc_top.sv
// dual channel 8-bit dac control: avalon-mm registers, enable decode, two channels
// assumes srst synchronous to core_clk and sw_standby driven by logic on core_clk
//
// What this block does
// RQ1: bit 7 enables channel 1 conversion and output
// RQ2: bit 6 enables channel 0 conversion and output
// RQ3: bit 5 makes both channels convert together
// RQ4: analog output enable follows only own bit
// RQ5: low five control bits read one, unwritable
// RQ6: all bits clear: nothing converts, outputs off
// RQ7: joint only: both convert, both outputs off
// RQ8: joint plus one enable: only that drives
// RQ9: result shown only after conversion time
// RQ10: output held until rewrite or disable
// RQ11: data write restarts conversion immediately
// RQ12: level is data over 256 times vref
// RQ13: clearing enable disables that analog output
// RQ14: starts stopped; registers locked until released
// RQ15: outputs retained throughout software standby
// RQ16: each channel has 8-bit read/write data
// RQ17: control writes take effect next clock edge
`timescale 1ns/1ps
`include "dacc_regs.svh"

module dacc_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sw_standby,
  output logic [7:0] ch0_analog_out,
  output logic ch0_analog_oe,
  output logic ch0_converting,
  output logic [7:0] ch1_analog_out,
  output logic ch1_analog_oe,
  output logic ch1_converting,
  output logic module_stopped
);

  dacc_pkg::dacc_avs_req_type req;
  dacc_pkg::dacc_ctrl_type ctrl_reg, ctrl_next;
  dacc_pkg::dacc_chan_ctl_type ch_ctl [2];
  dacc_pkg::dacc_chan_out_type ch_out [2];
  logic [7:0] data_reg [2];
  logic [7:0] data_next [2];
  logic mstop_reg, mstop_next;
  logic ack_reg;
  logic [31:0] readdata_reg, rd_value;
  logic [1:0] ch_oe;
  logic [1:0] data_wr;
  logic [1:0] oe_rise;

  assign req.read = avs_read;
  assign req.write = avs_write;
  assign req.address = avs_address;
  assign req.writedata = avs_writedata;
  assign req.byteenable = avs_byteenable;

  // one wait state per access: decode in the first cycle, commit in the second
  wire req_any = req.read | req.write;
  wire commit = req_any & ack_reg;
  wire wr_commit = commit & req.write & req.byteenable[0];

  assign avs_waitrequest = req_any & ~ack_reg;
  assign avs_readdata = readdata_reg;

  // while stopped only the stop register answers; the rest reads zero [RQ14]
  wire hit_ch0 = (req.address == `DACC_CH0_DATA_OFS) & ~mstop_reg;
  wire hit_ch1 = (req.address == `DACC_CH1_DATA_OFS) & ~mstop_reg;
  wire hit_ctrl = (req.address == `DACC_CONTROL_OFS) & ~mstop_reg;
  wire hit_mstop = (req.address == `DACC_MSTOP_OFS);

  wire wr_ch0 = wr_commit & hit_ch0;
  wire wr_ch1 = wr_commit & hit_ch1;
  wire wr_ctrl = wr_commit & hit_ctrl;
  wire wr_mstop = wr_commit & hit_mstop;

  wire [7:0] ctrl_byte = {ctrl_reg.ch1_output_enable, ctrl_reg.ch0_output_enable,
                          ctrl_reg.joint_conversion_enable, `DACC_RSVD_ONES}; // [RQ5]

  always_comb begin
    if (hit_ch0) begin
      rd_value = {24'h000000, data_reg[0]};
    end else if (hit_ch1) begin
      rd_value = {24'h000000, data_reg[1]};
    end else if (hit_ctrl) begin
      rd_value = {24'h000000, ctrl_byte};
    end else if (hit_mstop) begin
      rd_value = {31'h00000000, mstop_reg};
    end else begin
      rd_value = 32'h00000000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= req_any & ~ack_reg;
      if (req.read & ~ack_reg) begin
        readdata_reg <= rd_value;
      end
    end
  end

  // reserved low bits are never stored, so writes to them vanish [RQ5]
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next.ch1_output_enable = req.writedata[`DACC_CH1_OE_BIT]; // [RQ1]
      ctrl_next.ch0_output_enable = req.writedata[`DACC_CH0_OE_BIT]; // [RQ2]
      ctrl_next.joint_conversion_enable = req.writedata[`DACC_JOINT_BIT]; // [RQ3]
    end
    mstop_next = wr_mstop ? req.writedata[`DACC_MSTOP_BIT] : mstop_reg; // [RQ14]
  end

  assign data_wr = {wr_ch1, wr_ch0};
  assign ch_oe = {ctrl_reg.ch1_output_enable, ctrl_reg.ch0_output_enable};
  assign oe_rise[0] = wr_ctrl & req.writedata[`DACC_CH0_OE_BIT] & ~ctrl_reg.ch0_output_enable;
  assign oe_rise[1] = wr_ctrl & req.writedata[`DACC_CH1_OE_BIT] & ~ctrl_reg.ch1_output_enable;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg <= `DACC_CTRL_RESET;
      mstop_reg <= `DACC_MSTOP_RESET;
    end else begin
      ctrl_reg <= ctrl_next; // [RQ17]
      mstop_reg <= mstop_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      assign data_next[gi] = data_wr[gi] ? req.writedata[7:0] : data_reg[gi]; // [RQ16]

      always_ff @(posedge core_clk) begin
        if (srst) begin
          data_reg[gi] <= `DACC_DATA_RESET;
        end else begin
          data_reg[gi] <= data_next[gi];
        end
      end

      // joint enable widens conversion only; the output gate stays per channel
      assign ch_ctl[gi].conv_active = dacc_pkg::dacc_conv_active(ch_oe[gi],
        ctrl_reg.joint_conversion_enable, ~mstop_reg); // [RQ3] [RQ6] [RQ7] [RQ8]
      assign ch_ctl[gi].out_enable = ch_oe[gi] & ~mstop_reg; // [RQ4] [RQ13]
      assign ch_ctl[gi].hold = sw_standby; // [RQ15]

      dacc_chan u_chan (
        .core_clk(core_clk),
        .srst(srst),
        .ctl(ch_ctl[gi]),
        .data(data_reg[gi]),
        .restart(data_wr[gi]), // [RQ11]
        .flush(oe_rise[gi]), // [RQ9]
        .out(ch_out[gi])
      );
    end
  endgenerate

  assign ch0_analog_out = ch_out[0].code;
  assign ch0_analog_oe = ch_out[0].out_enable; // [RQ2]
  assign ch0_converting = ch_out[0].converting;
  assign ch1_analog_out = ch_out[1].code;
  assign ch1_analog_oe = ch_out[1].out_enable; // [RQ1]
  assign ch1_converting = ch_out[1].converting;
  assign module_stopped = mstop_reg;

  sequence s_ctrl_write;
    wr_ctrl;
  endsequence

  sequence s_bus_wait;
    req_any && avs_waitrequest;
  endsequence

  // a cleared enable drops the gate at once and the code one edge later
  sequence s_ch0_off;
    !ch0_analog_oe ##1 ch0_analog_out == `DACC_CODE_OFF;
  endsequence

  sequence s_ch1_off;
    !ch1_analog_oe ##1 ch1_analog_out == `DACC_CODE_OFF;
  endsequence

  a_ctrl_next_edge: assert property (@(posedge core_clk) disable iff (srst) // [RQ17]
    s_ctrl_write |=> ctrl_reg.ch1_output_enable == $past(req.writedata[7])
      && ctrl_reg.ch0_output_enable == $past(req.writedata[6])
      && ctrl_reg.joint_conversion_enable == $past(req.writedata[5]))
    else $error("control write not applied at next edge");

  a_rsvd_ones: assert property (@(posedge core_clk) disable iff (srst) // [RQ5]
    (req.read && !avs_waitrequest && hit_ctrl) |-> avs_readdata[4:0] == `DACC_RSVD_ONES)
    else $error("reserved control bits not read as ones");

  a_ch1_enable: assert property (@(posedge core_clk) disable iff (srst) // [RQ1]
    (ctrl_reg.ch1_output_enable && !mstop_reg) |-> ch1_converting && ch1_analog_oe)
    else $error("channel 1 enable not honoured");

  a_ch0_enable: assert property (@(posedge core_clk) disable iff (srst) // [RQ2]
    (ctrl_reg.ch0_output_enable && !mstop_reg) |-> ch0_converting && ch0_analog_oe)
    else $error("channel 0 enable not honoured");

  a_indep_conv: assert property (@(posedge core_clk) disable iff (srst) // [RQ3]
    (!ctrl_reg.joint_conversion_enable && !mstop_reg) |->
      ch0_converting == ctrl_reg.ch0_output_enable
      && ch1_converting == ctrl_reg.ch1_output_enable)
    else $error("independent conversion decode wrong");

  a_oe_own_bit: assert property (@(posedge core_clk) disable iff (srst) // [RQ4]
    ($changed(ctrl_reg.joint_conversion_enable) && $stable(ctrl_reg.ch0_output_enable)
     && $stable(ctrl_reg.ch1_output_enable) && $stable(mstop_reg)) |->
      $stable(ch0_analog_oe) && $stable(ch1_analog_oe))
    else $error("output enable moved with joint enable");

  a_all_off: assert property (@(posedge core_clk) disable iff (srst) // [RQ6]
    (ctrl_reg == `DACC_CTRL_RESET && !sw_standby) |->
      (!ch0_converting && !ch1_converting && !ch0_analog_oe && !ch1_analog_oe)
      ##1 (ch0_analog_out == `DACC_CODE_OFF && ch1_analog_out == `DACC_CODE_OFF))
    else $error("conversion or output active with all enables clear");

  a_joint_only: assert property (@(posedge core_clk) disable iff (srst) // [RQ7]
    (ctrl_reg.joint_conversion_enable && !ctrl_reg.ch0_output_enable
     && !ctrl_reg.ch1_output_enable && !mstop_reg) |->
      ch0_converting && ch1_converting && !ch0_analog_oe && !ch1_analog_oe)
    else $error("joint enable decode wrong");

  a_joint_one: assert property (@(posedge core_clk) disable iff (srst) // [RQ8]
    (ctrl_reg.joint_conversion_enable && (ctrl_reg.ch0_output_enable
     != ctrl_reg.ch1_output_enable) && !mstop_reg) |->
      ch0_converting && ch1_converting && ch0_analog_oe == ctrl_reg.ch0_output_enable
      && ch1_analog_oe == ctrl_reg.ch1_output_enable)
    else $error("joint plus single enable decode wrong");

  a_stop_locks: assert property (@(posedge core_clk) disable iff (srst) // [RQ14]
    (mstop_reg && commit && req.write && req.address != `DACC_MSTOP_OFS) |=>
      $stable(ctrl_reg) && $stable(data_reg[0]) && $stable(data_reg[1]))
    else $error("register changed while module stopped");

  a_data_store: assert property (@(posedge core_clk) disable iff (srst) // [RQ16]
    wr_ch1 |=> data_reg[1] == $past(req.writedata[7:0]))
    else $error("data write not stored");

  a_restart_now: assert property (@(posedge core_clk) disable iff (srst) // [RQ11]
    (wr_ch0 && ch0_converting && !sw_standby) |=> g_chan[0].u_chan.cnt_reg == '0
      && g_chan[0].u_chan.state_reg == dacc_pkg::ST_CONVERT)
    else $error("data write did not restart conversion");

  a_wait_once: assert property (@(posedge core_clk) disable iff (srst)
    s_bus_wait |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");

  a_wait_first: assert property (@(posedge core_clk) disable iff (srst)
    (req_any && !$past(req_any)) |-> avs_waitrequest)
    else $error("first cycle of an access not stalled");

  a_wait_idle: assert property (@(posedge core_clk) disable iff (srst)
    !req_any |-> !avs_waitrequest)
    else $error("waitrequest raised with no access");

  // a second commit of one request would apply a write twice
  a_one_commit: assert property (@(posedge core_clk) disable iff (srst)
    commit |=> !commit)
    else $error("one access committed twice");

  a_be_drop: assert property (@(posedge core_clk) disable iff (srst)
    (commit && req.write && !req.byteenable[0]) |=> $stable(ctrl_reg) && $stable(mstop_reg)
      && $stable(data_reg[0]) && $stable(data_reg[1]))
    else $error("write without low byte enable changed a register");

  a_data_store0: assert property (@(posedge core_clk) disable iff (srst) // [RQ16]
    wr_ch0 |=> data_reg[0] == $past(req.writedata[7:0]))
    else $error("channel 0 data write not stored");

  a_data_read: assert property (@(posedge core_clk) disable iff (srst) // [RQ16]
    (req.read && !avs_waitrequest && (hit_ch0 || hit_ch1)) |->
      avs_readdata == {24'h000000, (hit_ch0 ? data_reg[0] : data_reg[1])})
    else $error("data register read back wrong");

  a_ctrl_read: assert property (@(posedge core_clk) disable iff (srst) // [RQ5]
    (req.read && !avs_waitrequest && hit_ctrl) |-> avs_readdata == {24'h000000, ctrl_byte})
    else $error("control register read back wrong");

  // stopped reads fall through the decode to zero as well
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (srst) // [RQ14]
    (req.read && !avs_waitrequest && !(hit_ch0 || hit_ch1 || hit_ctrl || hit_mstop)) |->
      avs_readdata == 32'h00000000)
    else $error("unmapped or locked read not zero");

  a_stop_quiet: assert property (@(posedge core_clk) disable iff (srst) // [RQ14]
    mstop_reg |-> !ch0_converting && !ch1_converting && !ch0_analog_oe && !ch1_analog_oe)
    else $error("channel active while module stopped");

  a_stop_out_off: assert property (@(posedge core_clk) disable iff (srst) // [RQ14]
    (mstop_reg && !sw_standby) |=> ch0_analog_out == `DACC_CODE_OFF
      && ch1_analog_out == `DACC_CODE_OFF)
    else $error("analog code driven while module stopped");

  a_mstop_write: assert property (@(posedge core_clk) disable iff (srst) // [RQ14]
    wr_mstop |=> mstop_reg == $past(req.writedata[`DACC_MSTOP_BIT]))
    else $error("module stop write not applied");

  // entering stop keeps the settings for when the block is released
  a_stop_keeps: assert property (@(posedge core_clk) disable iff (srst) // [RQ14]
    $rose(mstop_reg) |-> $stable(ctrl_reg) && $stable(data_reg[0]) && $stable(data_reg[1]))
    else $error("settings lost on entering module stop");

  a_joint_conv: assert property (@(posedge core_clk) disable iff (srst) // [RQ3]
    (ctrl_reg.joint_conversion_enable && !mstop_reg) |-> ch0_converting && ch1_converting)
    else $error("joint enable did not start both channels");

  a_oe_gate: assert property (@(posedge core_clk) disable iff (srst) // [RQ4]
    ch0_analog_oe == (ctrl_reg.ch0_output_enable && !mstop_reg)
      && ch1_analog_oe == (ctrl_reg.ch1_output_enable && !mstop_reg))
    else $error("output enable not taken from its own bit");

  a_conv_off: assert property (@(posedge core_clk) disable iff (srst) // [RQ6]
    (!ch0_converting && !sw_standby) |=> g_chan[0].u_chan.state_reg == dacc_pkg::ST_IDLE)
    else $error("channel 0 kept converting while inactive");

  a_ch0_off: assert property (@(posedge core_clk) disable iff (srst) // [RQ13]
    ($fell(ctrl_reg.ch0_output_enable) && !sw_standby) |-> s_ch0_off)
    else $error("channel 0 output not disabled");

  a_ch1_off: assert property (@(posedge core_clk) disable iff (srst) // [RQ13]
    ($fell(ctrl_reg.ch1_output_enable) && !sw_standby) |-> s_ch1_off)
    else $error("channel 1 output not disabled");

  a_restart_ch1: assert property (@(posedge core_clk) disable iff (srst) // [RQ11]
    (wr_ch1 && ch1_converting && !sw_standby) |=> g_chan[1].u_chan.cnt_reg == '0
      && g_chan[1].u_chan.state_reg == dacc_pkg::ST_CONVERT)
    else $error("channel 1 data write did not restart conversion");

  a_standby_outs: assert property (@(posedge core_clk) disable iff (srst) // [RQ15]
    sw_standby |=> $stable(ch0_analog_out) && $stable(ch1_analog_out))
    else $error("analog code changed in software standby");

endmodule : dacc_top

// ===== include/dacc_pkg.sv
// types shared by the dac control top and its channel module
// assumes dacc_regs.svh is on the include path
package dacc_pkg;

  typedef struct packed {
    logic ch1_output_enable;
    logic ch0_output_enable;
    logic joint_conversion_enable;
  } dacc_ctrl_type;

  typedef struct packed {
    logic conv_active;
    logic out_enable;
    logic hold;
  } dacc_chan_ctl_type;

  typedef struct packed {
    logic [7:0] code;
    logic out_enable;
    logic converting;
  } dacc_chan_out_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } dacc_avs_req_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_READY = 2'b10
  } dacc_state_type;

  // a channel converts when running and either its own enable or the joint enable is set
  function automatic logic dacc_conv_active(input logic oe, input logic joint, input logic run);
    return run & (oe | joint);
  endfunction : dacc_conv_active

endpackage : dacc_pkg

// ===== include/dacc_regs.svh
// register offsets, field positions, reset values and timing counts of the dac control block
// assumes a 10 MHz core clock and a byte-addressed avalon-mm slave with a 4-bit address
`ifndef DACC_REGS_SVH
`define DACC_REGS_SVH

`define DACC_CH0_DATA_OFS 4'h0
`define DACC_CH1_DATA_OFS 4'h4
`define DACC_CONTROL_OFS 4'h8
`define DACC_MSTOP_OFS 4'hC

`define DACC_CH1_OE_BIT 7
`define DACC_CH0_OE_BIT 6
`define DACC_JOINT_BIT 5
`define DACC_MSTOP_BIT 0

`define DACC_RSVD_ONES 5'h1F
`define DACC_DATA_RESET 8'h00
`define DACC_CTRL_RESET 3'h0
`define DACC_MSTOP_RESET 1'h1
`define DACC_CODE_OFF 8'h00

`define DACC_CLK_PERIOD_NS 100
`define DACC_CONV_TIME_NS 10000
`define DACC_CONV_CYCLES (`DACC_CONV_TIME_NS / `DACC_CLK_PERIOD_NS)
`define DACC_CNT_W 7

`endif

// ===== tb/dacc_top_test.sv
// self-checking bench for the dual channel dac control top
// assumes dacc_regs.svh on the include path and the one wait state avalon slave of the top
`timescale 1ns/1ps
`include "dacc_regs.svh"

`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end

module dacc_top_test;
  localparam int CONV = `DACC_CONV_CYCLES;
  // ceiling well above the roughly 700 cycles the sequence needs
  localparam int CYCLE_LIMIT = 4000;

  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sw_standby = 1'b0;
  logic [7:0] ch0_analog_out;
  logic ch0_analog_oe;
  logic ch0_converting;
  logic [7:0] ch1_analog_out;
  logic ch1_analog_oe;
  logic ch1_converting;
  logic module_stopped;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc_count = 0;
  logic [31:0] rd;

  dacc_top i_dut (
    .core_clk(core_clk),
    .srst(srst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .sw_standby(sw_standby),
    .ch0_analog_out(ch0_analog_out),
    .ch0_analog_oe(ch0_analog_oe),
    .ch0_converting(ch0_converting),
    .ch1_analog_out(ch1_analog_out),
    .ch1_analog_oe(ch1_analog_oe),
    .ch1_converting(ch1_converting),
    .module_stopped(module_stopped)
  );

  always #50 core_clk = ~core_clk;

  task complete_run;
    $display("TB: compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // a hang anywhere ends here, since the bus tasks wait without their own bound
  always @(posedge core_clk) begin
    cyc_count++;
    if (cyc_count == CYCLE_LIMIT) begin
      bad_count++;
      complete_run();
    end
  end

  // one avalon access; returns at the accepting edge, request dropped right after it
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask : wr

  function automatic logic [7:0] chan_out(input int ch);
    return (ch == 1) ? ch1_analog_out : ch0_analog_out;
  endfunction : chan_out

  // old code must stand during the conversion, the new one must come just after it
  task conv_check(input int ch, input logic [7:0] old_code, input logic [7:0] new_code);
    int i;
    for (i = 1; i < CONV - 1; i++) begin
      @(posedge core_clk);
      #1;
      `CHK("held code", old_code, chan_out(ch));
    end
    i = 0;
    while (chan_out(ch) !== new_code && i < 6) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    `CHK("converted code", new_code, chan_out(ch));
  endtask : conv_check

  initial begin
    logic [2:0] m;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    `CHK("stopped after reset", 1'b1, module_stopped);
    `CHK("oe after reset", 2'b00, {ch1_analog_oe, ch0_analog_oe});
    // locked registers: write is dropped and read gives zero
    wr(`DACC_CH0_DATA_OFS, 8'h77);
    bus(1'b0, `DACC_CONTROL_OFS, 8'h00, rd);
    `CHK("control while stopped", 32'h0, rd);
    wr(`DACC_MSTOP_OFS, 8'h00);
    #1;
    `CHK("released", 1'b0, module_stopped);
    bus(1'b0, `DACC_CH0_DATA_OFS, 8'h00, rd);
    `CHK("data write while stopped", 32'h0, rd);
    bus(1'b0, `DACC_CONTROL_OFS, 8'h00, rd);
    `CHK("control reset value", 32'h1F, rd);
    wr(`DACC_CH0_DATA_OFS, 8'hA5);
    wr(`DACC_CH1_DATA_OFS, 8'h5A);
    bus(1'b0, `DACC_CH0_DATA_OFS, 8'h00, rd);
    `CHK("ch0 data", 32'hA5, rd);
    bus(1'b0, `DACC_CH1_DATA_OFS, 8'h00, rd);
    `CHK("ch1 data", 32'h5A, rd);
    // a write without the low byte lane must leave the register alone
    avs_byteenable <= 4'hE;
    wr(`DACC_CH0_DATA_OFS, 8'h99);
    avs_byteenable <= 4'hF;
    bus(1'b0, `DACC_CH0_DATA_OFS, 8'h00, rd);
    `CHK("masked data write", 32'hA5, rd);
    bus(1'b0, 4'h2, 8'h00, rd);
    `CHK("unmapped read", 32'h0, rd);
    // every combination of the three control bits, checked at the edge after the write
    for (int k = 0; k < 8; k++) begin
      m = k[2:0];
      wr(`DACC_CONTROL_OFS, {m, 5'h00});
      #1;
      `CHK("ch1 converting", m[2] | m[0], ch1_converting);
      `CHK("ch0 converting", m[1] | m[0], ch0_converting);
      `CHK("output enables", m[2:1], {ch1_analog_oe, ch0_analog_oe});
      bus(1'b0, `DACC_CONTROL_OFS, 8'h00, rd);
      `CHK("control readback", {24'h0, m, 5'h1F}, rd);
    end
    wr(`DACC_CONTROL_OFS, 8'h00);
    wr(`DACC_CH0_DATA_OFS, 8'h80);
    wr(`DACC_CONTROL_OFS, 8'h40);
    conv_check(0, 8'h00, 8'h80);
    wr(`DACC_CH0_DATA_OFS, 8'h3C);
    conv_check(0, 8'h80, 8'h3C);
    // standby freezes the channel even though the data register takes the write
    @(posedge core_clk);
    sw_standby <= 1'b1;
    wr(`DACC_CH0_DATA_OFS, 8'h11);
    repeat (CONV + 50) @(posedge core_clk);
    #1;
    `CHK("standby hold", 8'h3C, ch0_analog_out);
    `CHK("standby oe", 1'b1, ch0_analog_oe);
    @(posedge core_clk);
    sw_standby <= 1'b0;
    wr(`DACC_CONTROL_OFS, 8'h00);
    #1;
    `CHK("oe cleared", 1'b0, ch0_analog_oe);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("out cleared", 8'h00, ch0_analog_out);
    // joint with only ch0 enabled: ch1 converts yet stays off
    wr(`DACC_CH1_DATA_OFS, 8'hFF);
    wr(`DACC_CONTROL_OFS, 8'h60);
    repeat (CONV + 20) @(posedge core_clk);
    #1;
    `CHK("ch1 joint converting", 1'b1, ch1_converting);
    `CHK("ch1 joint oe", 1'b0, ch1_analog_oe);
    `CHK("ch1 joint out", 8'h00, ch1_analog_out);
    wr(`DACC_CONTROL_OFS, 8'hE0);
    conv_check(1, 8'h00, 8'hFF);
    wr(`DACC_MSTOP_OFS, 8'h01);
    #1;
    `CHK("stopped again", 1'b1, module_stopped);
    `CHK("oe when stopped", 2'b00, {ch1_analog_oe, ch0_analog_oe});
    `CHK("conv when stopped", 2'b00, {ch1_converting, ch0_converting});
    complete_run();
  end
endmodule : dacc_top_test
